// ==== rtl/tilt_target.sv ====
// target end of the tilt sensor read port: seven readable bytes
// assumes link pins from another clock domain, user writes on clock
// What this block does
// - port works only while enable high
// - any clock rate up to 400 kHz
// - target never holds the clock low
// - spikes up to 50 ns are ignored
// - data falling, clock high: start, take address
// - data rising, clock high: stop ends transfer
// - bus busy from start until stop
// - first byte: address plus direction, match only
// - own address 0x55, bytes 0xaa / 0xab
// - receiver pulls data low on ninth clock
// - write address, then pointer, both acknowledged
// - repeated start, read address, then data
// - data shifted msb first after falling edges
// - controller ends single read with nak, stop
// - burst: pointer advances after each ack
// - controller uses repeated start between phases
// - stop clears the stored pointer
// - pointer wraps from 0x06 to 0x00
// - enable low clears registers, high keeps them
`timescale 1ns/1ps
`default_nettype none
`include "tilt_params.svh"
module tilt_target (
    input  wire logic        clock,
    input  wire logic        reset_n,
    tilt_link_if.device      link,
    input  wire logic        sensorEnable,
    input  wire logic        regWe,
    input  wire logic [2:0]  regAddr,
    input  wire logic [7:0]  regWdata,
    output logic             busy
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [1:0] sclSync_reg;
    logic [1:0] sdaSync_reg;
    logic [1:0] enSync_reg;
    logic [1:0] raw;
    logic [1:0] filt;
    logic       sclPrev_reg;
    logic       sdaPrev_reg;
    logic       en;

    // two flops per outside input
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sclSync_reg <= 2'h3;
            sdaSync_reg <= 2'h3;
            enSync_reg  <= 2'h0;
        end else begin
            sclSync_reg <= {sclSync_reg[0], link.scl};
            sdaSync_reg <= {sdaSync_reg[0], link.sda};
            enSync_reg  <= {enSync_reg[0], sensorEnable};
        end
    end
    assign raw = {sdaSync_reg[1], sclSync_reg[1]};
    assign en  = enSync_reg[1];

    // ------------------------------------------------------------
    // spike filter: a level is taken once stable longer than a spike
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gFilt
            logic [2:0] cnt_reg;
            logic       f_reg;
            always_ff @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    cnt_reg <= 3'h0;
                    f_reg   <= 1'b1;
                end else if (raw[g] == f_reg) begin
                    cnt_reg <= 3'h0;
                end else if (cnt_reg == 3'(`TILT_SPIKE_CYC)) begin
                    cnt_reg <= 3'h0;
                    f_reg   <= raw[g];
                end else begin
                    cnt_reg <= cnt_reg + 3'h1;
                end
            end
            assign filt[g] = f_reg;
        end
    endgenerate

    // previous filtered levels for edge finding
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sclPrev_reg <= 1'b1;
            sdaPrev_reg <= 1'b1;
        end else begin
            sclPrev_reg <= filt[0];
            sdaPrev_reg <= filt[1];
        end
    end

    logic sclRise;
    logic sclFall;
    logic startDet;
    logic stopDet;
    // edges and bus conditions, sampled at any link rate
    assign sclRise  = filt[0] & ~sclPrev_reg;
    assign sclFall  = ~filt[0] & sclPrev_reg;
    assign startDet = filt[0] & sclPrev_reg & ~filt[1] & sdaPrev_reg;
    assign stopDet  = filt[0] & sclPrev_reg & filt[1] & ~sdaPrev_reg;

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [7:0] regs [`TILT_NREGS];
    generate
        for (g = 0; g < `TILT_NREGS; g++) begin : gReg
            always_ff @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    regs[g] <= 8'h00;
                end else if (!en) begin
                    regs[g] <= 8'h00;
                end else if (regWe && regAddr == 3'(g)) begin
                    regs[g] <= regWdata;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // protocol state machine
    // ------------------------------------------------------------
    tilt_pkg::tgt_state_t state_reg;
    logic [3:0] bitCnt_reg;
    logic [7:0] shift_reg;
    logic       rw_reg;
    logic       acked_reg;
    logic       sdaLow_reg;
    logic [7:0] ptr_reg;
    logic [7:0] ptrNext;
    logic       ptrLoad;
    logic       ptrAdv;
    logic [7:0] curByte;
    logic [7:0] nextByte;

    // wrap after the last register
    assign ptrNext = (ptr_reg >= `TILT_LAST_REG) ? 8'h00 : ptr_reg + 8'h01;
    assign ptrLoad = (state_reg == tilt_pkg::T_PTR) && sclFall && bitCnt_reg == 4'h8;
    assign ptrAdv  = (state_reg == tilt_pkg::T_HACK) && sclFall && acked_reg;
    // byte at the pointer and at the next pointer, zero outside the map
    assign curByte  = (ptr_reg <= `TILT_LAST_REG) ? regs[ptr_reg[2:0]] : 8'h00;
    assign nextByte = (ptrNext <= `TILT_LAST_REG) ? regs[ptrNext[2:0]] : 8'h00;

    // stored pointer, cleared by stop and by enable low
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ptr_reg <= 8'h00;
        end else if (!en || stopDet) begin
            ptr_reg <= 8'h00;
        end else if (ptrLoad && !startDet) begin
            ptr_reg <= shift_reg;
        end else if (ptrAdv && !startDet) begin
            ptr_reg <= ptrNext;
        end
    end

    // bit engine; only the data line is ever driven, never the clock
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_reg  <= tilt_pkg::T_IDLE;
            bitCnt_reg <= 4'h0;
            shift_reg  <= 8'h00;
            rw_reg     <= 1'b0;
            acked_reg  <= 1'b0;
            sdaLow_reg <= 1'b0;
        end else if (!en) begin
            state_reg  <= tilt_pkg::T_IDLE;
            sdaLow_reg <= 1'b0;
        end else if (stopDet) begin
            state_reg  <= tilt_pkg::T_IDLE;
            sdaLow_reg <= 1'b0;
        end else if (startDet) begin
            state_reg  <= tilt_pkg::T_ADDR;
            bitCnt_reg <= 4'h0;
            sdaLow_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                tilt_pkg::T_IDLE, tilt_pkg::T_IGN: begin
                    sdaLow_reg <= 1'b0;
                end
                tilt_pkg::T_ADDR, tilt_pkg::T_PTR: begin
                    if (sclRise && bitCnt_reg < 4'h8) begin
                        shift_reg  <= {shift_reg[6:0], filt[1]};
                        bitCnt_reg <= bitCnt_reg + 4'h1;
                    end else if (sclFall && bitCnt_reg == 4'h8) begin
                        bitCnt_reg <= 4'h0;
                        if (state_reg == tilt_pkg::T_PTR) begin
                            sdaLow_reg <= 1'b1;
                            state_reg  <= tilt_pkg::T_ACKP;
                        end else if (shift_reg[7:1] == `TILT_ADDR) begin
                            sdaLow_reg <= 1'b1;
                            rw_reg     <= shift_reg[0];
                            state_reg  <= tilt_pkg::T_ACKA;
                        end else begin
                            state_reg  <= tilt_pkg::T_IGN;
                        end
                    end
                end
                tilt_pkg::T_ACKA: begin
                    if (sclFall) begin
                        if (rw_reg == `TILT_RW_READ) begin
                            shift_reg  <= curByte;
                            sdaLow_reg <= ~curByte[7];
                            state_reg  <= tilt_pkg::T_TX;
                        end else begin
                            sdaLow_reg <= 1'b0;
                            state_reg  <= tilt_pkg::T_PTR;
                        end
                    end
                end
                tilt_pkg::T_ACKP: begin
                    if (sclFall) begin
                        sdaLow_reg <= 1'b0;
                        state_reg  <= tilt_pkg::T_IGN; // further writes not taken
                    end
                end
                tilt_pkg::T_TX: begin
                    if (sclFall) begin
                        bitCnt_reg <= bitCnt_reg + 4'h1;
                        if (bitCnt_reg == 4'h7) begin
                            sdaLow_reg <= 1'b0;
                            state_reg  <= tilt_pkg::T_HACK;
                        end else begin
                            shift_reg  <= {shift_reg[6:0], 1'b0};
                            sdaLow_reg <= ~shift_reg[6];
                        end
                    end
                end
                tilt_pkg::T_HACK: begin
                    if (sclRise) begin
                        acked_reg <= ~filt[1];
                    end else if (sclFall) begin
                        bitCnt_reg <= 4'h0;
                        if (acked_reg) begin
                            shift_reg  <= nextByte;
                            sdaLow_reg <= ~nextByte[7];
                            state_reg  <= tilt_pkg::T_TX;
                        end else begin
                            state_reg  <= tilt_pkg::T_IGN;
                        end
                    end
                end
            endcase
        end
    end

    // open-drain data pin; the clock pin has no driver here
    assign link.devSdaOut = 1'b0;
    assign link.devSdaOe  = sdaLow_reg;
    assign busy           = (state_reg != tilt_pkg::T_IDLE);
endmodule : tilt_target
`default_nettype wire

// ==== inc/tilt_params.svh ====
// constants shared by both ends of the tilt sensor read port
// assumes a 100 MHz core clock on each end
`ifndef TILT_PARAMS_SVH
`define TILT_PARAMS_SVH
`define TILT_ADDR 7'h55
`define TILT_RW_WRITE 1'b0
`define TILT_RW_READ 1'b1
`define TILT_LAST_REG 8'h06
`define TILT_NREGS 7
`define TILT_CLK_MHZ 100
`define TILT_SPIKE_NS 50
`define TILT_SPIKE_CYC ((`TILT_SPIKE_NS * `TILT_CLK_MHZ) / 1000)
`define TILT_SCL_KHZ 400
`define TILT_QTR_CYC ((`TILT_CLK_MHZ * 1000 + 4 * `TILT_SCL_KHZ - 1) / (4 * `TILT_SCL_KHZ))
`define TILT_FIFO_W 8
`define TILT_FIFO_D 32
`endif

// ==== inc/tilt_pkg.sv ====
// state types for the target and controller ends
// assumes nothing of its surroundings
package tilt_pkg;
    typedef enum logic [7:0] {
        T_IDLE = 8'h01,
        T_ADDR = 8'h02,
        T_ACKA = 8'h04,
        T_PTR  = 8'h08,
        T_ACKP = 8'h10,
        T_TX   = 8'h20,
        T_HACK = 8'h40,
        T_IGN  = 8'h80
    } tgt_state_t;
    typedef enum logic [7:0] {
        H_IDLE = 8'h01,
        H_STA  = 8'h02,
        H_WADR = 8'h04,
        H_WPTR = 8'h08,
        H_RSTA = 8'h10,
        H_RADR = 8'h20,
        H_READ = 8'h40,
        H_STOP = 8'h80
    } host_state_t;
endpackage : tilt_pkg

// ==== inc/tilt_link_if.sv ====
// two-wire link between controller and target, open drain
// assumes pull-ups: a line is low only while some end pulls it low
`timescale 1ns/1ps
`default_nettype none
interface tilt_link_if;
    logic hostSclOut;
    logic hostSclOe;
    logic hostSdaOut;
    logic hostSdaOe;
    logic devSdaOut;
    logic devSdaOe;
    wire  scl;
    wire  sda;
    // wired-and resolution of both ends on data; the clock is driven by the controller alone
    assign scl = ~(hostSclOe & ~hostSclOut);
    assign sda = ~((hostSdaOe & ~hostSdaOut) | (devSdaOe & ~devSdaOut));
    modport device (input scl, input sda, output devSdaOut, output devSdaOe);
    modport host (input scl, input sda, output hostSclOut, output hostSclOe,
                  output hostSdaOut, output hostSdaOe);
endinterface : tilt_link_if
`default_nettype wire

// ==== rtl/tilt_controller.sv ====
// controller end: pointer write, repeated start, burst read into a fifo
// assumes a 100 MHz clock; the target never stretches the clock
`timescale 1ns/1ps
`default_nettype none
`include "tilt_params.svh"
// ------------------------------------------------------------
// flop fifo with valid and ready on both sides
// ------------------------------------------------------------
module tilt_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    input  wire logic         clock,
    input  wire logic         reset_n,
    input  wire logic         inValid,
    output logic              inReady,
    input  wire logic [W-1:0] inData,
    output logic              outValid,
    input  wire logic         outReady,
    output logic [W-1:0]      outData
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0]  wr_reg;
    logic [AW:0]  rd_reg;
    assign inReady  = (wr_reg - rd_reg) != (AW+1)'(D);
    assign outValid = wr_reg != rd_reg;
    assign outData  = mem[rd_reg[AW-1:0]];
    // pointers with a wrap bit
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            if (inValid && inReady) wr_reg <= wr_reg + 1'b1;
            if (outValid && outReady) rd_reg <= rd_reg + 1'b1;
        end
    end
    // storage
    always_ff @(posedge clock) begin
        if (inValid && inReady) mem[wr_reg[AW-1:0]] <= inData;
    end
endmodule : tilt_fifo

module tilt_controller (
    input  wire logic        clock,
    input  wire logic        reset_n,
    tilt_link_if.host        link,
    input  wire logic        sensorEnable,
    input  wire logic        cmdValid,
    output logic             cmdReady,
    input  wire logic [7:0]  cmdPtr,
    input  wire logic [7:0]  cmdCount,
    output logic             rdValid,
    input  wire logic        rdReady,
    output logic [7:0]       rdData,
    output logic             busy,
    output logic             nakErr
);
    // ------------------------------------------------------------
    // sync and quarter-bit divider
    // ------------------------------------------------------------
    logic [1:0] sdaSync_reg;
    logic [1:0] enSync_reg;
    logic [6:0] div_reg;
    logic       tick;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sdaSync_reg <= 2'h3;
            enSync_reg  <= 2'h0;
        end else begin
            sdaSync_reg <= {sdaSync_reg[0], link.sda};
            enSync_reg  <= {enSync_reg[0], sensorEnable};
        end
    end
    // clock rate held at or below 400 kHz
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) div_reg <= 7'h00;
        else if (tick) div_reg <= 7'h00;
        else div_reg <= div_reg + 7'h01;
    end
    assign tick = (div_reg == 7'(`TILT_QTR_CYC - 1));

    // ------------------------------------------------------------
    // transfer sequencer
    // ------------------------------------------------------------
    tilt_pkg::host_state_t state_reg;
    logic [1:0] q_reg;
    logic [3:0] bit_reg;
    logic [7:0] tx_reg;
    logic [7:0] rx_reg;
    logic [7:0] ptr_reg;
    logic [7:0] left_reg;
    logic       sclLow_reg;
    logic       sdaLow_reg;
    logic       ackOk_reg;
    logic       nak_reg;
    logic       fifoInReady;
    logic       push;
    logic       adv;
    logic       wrByte;

    assign wrByte = state_reg inside {tilt_pkg::H_WADR, tilt_pkg::H_WPTR, tilt_pkg::H_RADR};
    // a read byte starts only with room in the fifo
    assign adv  = tick && !(state_reg == tilt_pkg::H_READ && q_reg == 2'h0
                  && bit_reg == 4'h0 && !fifoInReady);
    assign push = adv && state_reg == tilt_pkg::H_READ && q_reg == 2'h3 && bit_reg == 4'h7;
    assign cmdReady = (state_reg == tilt_pkg::H_IDLE) && enSync_reg[1];

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_reg  <= tilt_pkg::H_IDLE;
            q_reg      <= 2'h0;
            bit_reg    <= 4'h0;
            tx_reg     <= 8'h00;
            rx_reg     <= 8'h00;
            ptr_reg    <= 8'h00;
            left_reg   <= 8'h00;
            sclLow_reg <= 1'b0;
            sdaLow_reg <= 1'b0;
            ackOk_reg  <= 1'b0;
            nak_reg    <= 1'b0;
        end else if (state_reg == tilt_pkg::H_IDLE) begin
            q_reg <= 2'h0;
            if (cmdValid && cmdReady) begin
                ptr_reg   <= cmdPtr;
                left_reg  <= (cmdCount == 8'h00) ? 8'h01 : cmdCount;
                nak_reg   <= 1'b0;
                state_reg <= tilt_pkg::H_STA;
            end
        end else if (adv) begin
            q_reg <= q_reg + 2'h1;
            unique case (state_reg)
                tilt_pkg::H_STA: begin
                    if (q_reg == 2'h0) sdaLow_reg <= 1'b1;
                    if (q_reg == 2'h2) sclLow_reg <= 1'b1;
                    if (q_reg == 2'h3) begin
                        tx_reg    <= {`TILT_ADDR, `TILT_RW_WRITE};
                        bit_reg   <= 4'h0;
                        state_reg <= tilt_pkg::H_WADR;
                    end
                end
                tilt_pkg::H_RSTA: begin
                    if (q_reg == 2'h0) sdaLow_reg <= 1'b0;
                    if (q_reg == 2'h1) sclLow_reg <= 1'b0;
                    if (q_reg == 2'h2) sdaLow_reg <= 1'b1;
                    if (q_reg == 2'h3) begin
                        sclLow_reg <= 1'b1;
                        tx_reg     <= {`TILT_ADDR, `TILT_RW_READ};
                        bit_reg    <= 4'h0;
                        state_reg  <= tilt_pkg::H_RADR;
                    end
                end
                tilt_pkg::H_READ: begin
                    if (q_reg == 2'h0) sdaLow_reg <= (bit_reg == 4'h8) && (left_reg != 8'h01);
                    if (q_reg == 2'h1) sclLow_reg <= 1'b0;
                    if (q_reg == 2'h2 && bit_reg < 4'h8) rx_reg <= {rx_reg[6:0], sdaSync_reg[1]};
                    if (q_reg == 2'h3) begin
                        sclLow_reg <= 1'b1;
                        bit_reg    <= bit_reg + 4'h1;
                        if (bit_reg == 4'h8) begin
                            bit_reg  <= 4'h0;
                            left_reg <= left_reg - 8'h01;
                            if (left_reg == 8'h01) state_reg <= tilt_pkg::H_STOP;
                        end
                    end
                end
                tilt_pkg::H_STOP: begin
                    if (q_reg == 2'h0) sdaLow_reg <= 1'b1;
                    if (q_reg == 2'h1) sclLow_reg <= 1'b0;
                    if (q_reg == 2'h2) sdaLow_reg <= 1'b0;
                    if (q_reg == 2'h3) state_reg <= tilt_pkg::H_IDLE;
                end
                default: begin
                    // address and pointer bytes, ack read on the ninth clock
                    if (q_reg == 2'h0) sdaLow_reg <= (bit_reg < 4'h8) && !tx_reg[7];
                    if (q_reg == 2'h1) sclLow_reg <= 1'b0;
                    if (q_reg == 2'h2 && bit_reg == 4'h8) ackOk_reg <= !sdaSync_reg[1];
                    if (q_reg == 2'h3) begin
                        sclLow_reg <= 1'b1;
                        tx_reg     <= {tx_reg[6:0], 1'b0};
                        bit_reg    <= bit_reg + 4'h1;
                        if (bit_reg == 4'h8 && wrByte) begin
                            bit_reg <= 4'h0;
                            if (!ackOk_reg) begin
                                nak_reg   <= 1'b1;
                                state_reg <= tilt_pkg::H_STOP;
                            end else if (state_reg == tilt_pkg::H_WADR) begin
                                tx_reg    <= ptr_reg;
                                state_reg <= tilt_pkg::H_WPTR;
                            end else if (state_reg == tilt_pkg::H_WPTR) begin
                                state_reg <= tilt_pkg::H_RSTA;
                            end else begin
                                state_reg <= tilt_pkg::H_READ;
                            end
                        end
                    end
                end
            endcase
        end
    end

    // received bytes go through the fifo to the user
    tilt_fifo #(.W(`TILT_FIFO_W), .D(`TILT_FIFO_D)) tilt_fifo_i (
        .clock    (clock),
        .reset_n  (reset_n),
        .inValid  (push),
        .inReady  (fifoInReady),
        .inData   (rx_reg),
        .outValid (rdValid),
        .outReady (rdReady),
        .outData  (rdData)
    );

    assign link.hostSclOut = 1'b0;
    assign link.hostSclOe  = sclLow_reg;
    assign link.hostSdaOut = 1'b0;
    assign link.hostSdaOe  = sdaLow_reg;
    assign busy            = (state_reg != tilt_pkg::H_IDLE);
    assign nakErr          = nak_reg;
endmodule : tilt_controller
`default_nettype wire

// ==== sim/tilt_link_checker.sv ====
// wire-level checks on the tilt link
// assumes one core clock watching both lines
`timescale 1ns/1ps
`default_nettype none
module tilt_link_checker (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic hostSclOe,
    input wire logic devSdaOe,
    input wire logic devSdaOut,
    input wire logic scl,
    input wire logic sda
);
    logic       sdaQ, sclQ, busyW, rdDir;
    logic [3:0] bitNo;
    logic [1:0] byteNo;
    wire        rise = scl & ~sclQ;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    // frame position seen on the pins
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) {sdaQ, sclQ, busyW, rdDir, bitNo, byteNo} <= 10'h300;
        else begin
            {sdaQ, sclQ} <= {sda, scl};
            if (sdaQ & ~sda & scl & sclQ) {busyW, bitNo, byteNo} <= 7'h40;
            else if (~sdaQ & sda & scl & sclQ) busyW <= 1'b0;
            else if (rise) begin
                bitNo <= bitNo + 4'h1;
                if (bitNo == 4'h7 && byteNo == 2'h0) rdDir <= sda;
            end else if (~scl & sclQ & bitNo == 4'h9) begin
                bitNo <= 4'h0;
                byteNo <= byteNo + {1'b0, byteNo != 2'h3};
            end
        end
    end
    sequence ackRise; rise && bitNo == 4'h8; endsequence
    a_scl_host_only: assert property (!scl |-> hostSclOe) else $error("clock low, no owner");
    a_idle_released: assert property (!busyW |-> !devSdaOe) else $error("data driven when free");
    a_idle_scl_high: assert property (!busyW |-> scl) else $error("clock low when free");
    a_change_scl_low: assert property ($changed(devSdaOe) |-> !scl) else $error("data moved, clock high");
    a_ack_stable: assert property (ackRise |-> $stable(devSdaOe) [*8]) else $error("ack not stable");
    a_rx_released: assert property ((byteNo == 2'h0 || !rdDir) && bitNo inside {[4'h1:4'h7]}
        |-> !devSdaOe) else $error("target drove while receiving");
    a_addr_acked: assert property (ackRise ##0 (byteNo == 2'h0 || (byteNo == 2'h1 && !rdDir))
        |-> devSdaOe && !devSdaOut && !sda) else $error("byte not acked");
    a_ack_slot_free: assert property (ackRise ##0 (rdDir && byteNo != 2'h0) |-> !devSdaOe)
        else $error("ack slot not released");
endmodule : tilt_link_checker
`default_nettype wire

// ==== sim/tb_tilt_sensor_i2c_read_port.sv ====
// bench: both ends on one link, user ports driven
// assumes design, interface and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_tilt_sensor_i2c_read_port;
    logic       clock = 1'b0, reset_n = 1'b0, sensorEnable = 1'b1;
    logic       regWe = 1'b0, cmdValid = 1'b0, rdReady = 1'b0;
    logic       cmdReady, rdValid, hostBusy, tgtBusy, nakErr;
    logic [2:0] regAddr = 3'h0;
    logic [7:0] regWdata = 8'h00, cmdPtr = 8'h00, cmdCount = 8'h00, rdData;
    int         errCount = 0, checks = 0, n, k;
    tilt_link_if link ();
    tilt_target tilt_target_i (.clock, .reset_n, .link, .sensorEnable, .regWe, .regAddr, .regWdata,
        .busy(tgtBusy));
    tilt_controller tilt_controller_i (.clock, .reset_n, .link, .sensorEnable, .cmdValid, .cmdReady,
        .cmdPtr, .cmdCount, .rdValid, .rdReady, .rdData, .busy(hostBusy), .nakErr);
    tilt_link_checker tilt_link_checker_i (.clock, .reset_n, .hostSclOe(link.hostSclOe),
        .devSdaOe(link.devSdaOe), .devSdaOut(link.devSdaOut), .scl(link.scl), .sda(link.sda));
    // core clock, and a guard sized above the ~110000 cycles of the run
    initial forever #5 clock = ~clock;
    initial begin
        repeat (140000) @(posedge clock);
        errCount++;
        finalReport();
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            errCount++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic finalReport();
        if (errCount == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : finalReport
    task automatic regWrite(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        {regWe, regAddr, regWdata} <= {1'b1, a, d};
        @(posedge clock);
        regWe <= 1'b0;
    endtask : regWrite
    task automatic readCmd(input logic [7:0] p, input logic [7:0] c);
        @(posedge clock);
        {cmdValid, cmdPtr, cmdCount} <= {1'b1, p, c};
        @(negedge clock);
        for (n = 0; n < 400 && cmdReady !== 1'b1; n++) @(negedge clock);
        check({7'h00, cmdReady}, 8'h01);
        @(posedge clock);
        cmdValid <= 1'b0;
    endtask : readCmd
    task automatic popByte(input logic [7:0] e);
        @(negedge clock);
        for (n = 0; n < 12000 && rdValid !== 1'b1; n++) @(negedge clock);
        check({7'h00, rdValid}, 8'h01);
        check(rdData, e);
        @(posedge clock);
    endtask : popByte
    task automatic waitIdle();
        @(negedge clock);
        for (n = 0; n < 6000 && (hostBusy | tgtBusy) !== 1'b0; n++) @(negedge clock);
        check({6'h00, hostBusy | tgtBusy, nakErr}, 8'h00);
    endtask : waitIdle
    // reset, load registers, then single read, stalled burst, enable drop
    initial begin
        repeat (6) @(posedge clock);
        reset_n <= 1'b1;
        // enable needs two edges through its synchroniser before writes land
        repeat (2) @(posedge clock);
        for (int i = 0; i < 7; i++) regWrite(3'(i), 8'hc3 + 8'(i) * 8'h11);
        rdReady <= 1'b1;
        readCmd(8'h03, 8'h01);
        popByte(8'hf6);
        check({7'h00, tgtBusy}, 8'h01);
        waitIdle();
        @(posedge clock) rdReady <= 1'b0;
        readCmd(8'h05, 8'h21);
        k = 0;
        for (n = 0; n < 100000 && k < 600; n++) @(negedge clock) k = link.scl ? 0 : k + 1;
        check({6'h00, hostBusy, k == 600}, 8'h03);
        @(posedge clock) rdReady <= 1'b1;
        for (int i = 5; i < 38; i++) popByte(8'hc3 + 8'(i % 7) * 8'h11);
        waitIdle();
        @(posedge clock) sensorEnable <= 1'b0;
        repeat (4) @(posedge clock);
        regWrite(3'h0, 8'h5a);
        @(posedge clock) sensorEnable <= 1'b1;
        readCmd(8'h06, 8'h02);
        popByte(8'h00);
        popByte(8'h00);
        waitIdle();
        finalReport();
    end
endmodule : tb_tilt_sensor_i2c_read_port
`default_nettype wire
